/* src/map_pkg.sv */
// Constants for the mode-muxed upper address port
// Function
// - ROM-disabled expanded mode: direction bits fixed at 1, writes ignored, read as 1.
// - ROM-disabled expanded mode: all eight pins drive upper address bits 15..8.
// - ROM-enabled expanded mode: direction 1 drives address bit, 0 makes input.
// - Single-chip mode: direction 1 drives output latch bit, 0 makes input.
// - In ROM-enabled and single-chip modes direction reads back all ones.
// - Direction clears to 00 on reset and hardware standby; FF in ROM-disabled mode.
// - Software standby keeps direction contents and output pins keep driving.
// - Port read of an output bit returns the output latch bit.
// - Port read of an input bit returns the pin level.
// - Output latch clears on reset and hardware standby, kept through software standby.
// - Pull-up on when select bit is 1 and direction bit is 0, per bit.
// - Pull-ups off in ROM-disabled mode, and during reset and hardware standby.
// - Pull-up select clears on reset and hardware standby, kept in software standby.
// - Hardware standby puts the address output pins in high impedance.
package map_pkg;
  localparam int          PORT_W       = 8;
  localparam int          ADDR_W       = 18;
  localparam logic [15:0] IDX_PULLUP   = 16'hFFAD;
  localparam logic [15:0] IDX_DIR      = 16'hFFB1;
  localparam logic [15:0] IDX_LATCH    = 16'hFFB3;
  localparam logic [7:0]  RST_PULLUP   = 8'h00;
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [7:0]  RST_LATCH    = 8'h00;
  localparam logic [7:0]  DIR_FIXED    = 8'hFF;
  localparam logic [7:0]  DIR_READ     = 8'hFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    MAP_MODE_RSV   = 2'b00,
    MAP_MODE_NOROM = 2'b01,
    MAP_MODE_ROM   = 2'b10,
    MAP_MODE_CHIP  = 2'b11
  } map_mode_t;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] map_byte_addr(input logic [15:0] idx);
    map_byte_addr = {idx, 2'b00};
  endfunction
endpackage

/* src/map_sync_if.sv */
// Pin levels before and after synchronisation
interface map_sync_if;
  logic [map_pkg::PORT_W-1:0] raw;
  logic [map_pkg::PORT_W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

/* src/map_sync.sv */
// Two-flop synchroniser for the port pin levels
module map_sync (
  input wire logic aclk,
  input wire logic aresetn,
  map_sync_if.dst  sif
);
  import map_pkg::*;

  logic [PORT_W-1:0] meta_r;
  logic [PORT_W-1:0] sync_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= sif.raw;
      sync_r <= meta_r;
    end
  end

  assign sif.synced = sync_r;
endmodule

/* src/map_port.sv */
// Mode-muxed upper address port with AXI4-Lite register access
module map_port (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [map_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [map_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire map_pkg::map_mode_t        op_mode,
  input  wire logic                      hw_standby,
  input  wire logic                      sw_standby,
  input  wire logic [map_pkg::PORT_W-1:0] upper_address_bits,
  input  wire logic [map_pkg::PORT_W-1:0] pin_in,
  output logic [map_pkg::PORT_W-1:0]     pin_out,
  output logic [map_pkg::PORT_W-1:0]     pin_oe,
  output logic [map_pkg::PORT_W-1:0]     pullup_en
);
  import map_pkg::*;

  logic [PORT_W-1:0] pullup_select_r;
  logic [PORT_W-1:0] pin_direction_r;
  logic [PORT_W-1:0] output_latch_r;
  logic [PORT_W-1:0] dir_eff;
  logic [PORT_W-1:0] port_read;
  logic              mode_norom;
  logic              mode_chip;

  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              wr_fire;
  logic              wr_lane0;

  logic [PORT_W-1:0] pout_r;
  logic [PORT_W-1:0] poe_r;
  logic [PORT_W-1:0] pup_r;

  map_sync_if sif ();

  assign sif.raw = pin_in;

  map_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif)
  );

  assign mode_norom = (op_mode == MAP_MODE_NOROM);
  assign mode_chip  = (op_mode == MAP_MODE_CHIP) || (op_mode == MAP_MODE_RSV);

  // Direction seen by the pins: fixed outputs when ROM is off
  assign dir_eff = mode_norom ? DIR_FIXED : pin_direction_r;

  // Output bits read the latch, input bits read the synchronised pin
  assign port_read = (dir_eff & output_latch_r) | (~dir_eff & sif.synced);

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got_r      <= 1'b0;
      awaddr_r      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_r      <= 1'b1;
      awaddr_r      <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_r      <= 1'b0;
    end else if (!aw_got_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got_r      <= 1'b0;
      wdata_r      <= '0;
      wstrb_r      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_r      <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_r      <= 1'b0;
    end else if (!w_got_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && wstrb_r[0] && !hw_standby;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r == map_byte_addr(IDX_PULLUP)) begin
        s_axi_bresp <= RESP_OKAY;
      end else if (awaddr_r == map_byte_addr(IDX_DIR)) begin
        s_axi_bresp <= RESP_OKAY;
      end else if (awaddr_r == map_byte_addr(IDX_LATCH)) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Registers: hardware standby holds them at their reset values
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_direction_r <= RST_DIR;
    end else if (wr_lane0 && !mode_norom && awaddr_r == map_byte_addr(IDX_DIR)) begin
      pin_direction_r <= wdata_r[PORT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      output_latch_r <= RST_LATCH;
    end else if (wr_lane0 && awaddr_r == map_byte_addr(IDX_LATCH)) begin
      output_latch_r <= wdata_r[PORT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pullup_select_r <= RST_PULLUP;
    end else if (wr_lane0 && awaddr_r == map_byte_addr(IDX_PULLUP)) begin
      pullup_select_r <= wdata_r[PORT_W-1:0];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (s_axi_araddr == map_byte_addr(IDX_PULLUP)) begin
        s_axi_rdata <= {24'h000000, pullup_select_r};
      end else if (s_axi_araddr == map_byte_addr(IDX_DIR)) begin
        s_axi_rdata <= {24'h000000, DIR_READ};
      end else if (s_axi_araddr == map_byte_addr(IDX_LATCH)) begin
        s_axi_rdata <= {24'h000000, port_read};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Pin drive: software standby changes nothing here, so outputs keep driving
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pout_r <= '0;
      poe_r  <= '0;
    end else begin
      pout_r <= mode_chip ? output_latch_r : upper_address_bits;
      poe_r  <= hw_standby ? '0 : dir_eff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pup_r <= '0;
    end else if (hw_standby || mode_norom) begin
      pup_r <= '0;
    end else begin
      pup_r <= pullup_select_r & ~pin_direction_r;
    end
  end

  assign pin_out   = pout_r;
  assign pin_oe    = poe_r;
  assign pullup_en = pup_r;

  logic unused_ok;
  assign unused_ok = sw_standby ^ (^wdata_r[31:PORT_W]) ^ (^wstrb_r[3:1]);
endmodule

/* sim/map_asserts.sv */
// Port checks for the mode-muxed address port
module map_asserts (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [map_pkg::ADDR_W-1:0]  s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire map_pkg::map_mode_t          op_mode,
  input wire logic                        hw_standby,
  input wire logic [7:0]                  upper_address_bits,
  input wire logic [7:0]                  pin_out,
  input wire logic [7:0]                  pin_oe,
  input wire logic [7:0]                  pullup_en
);
  import map_pkg::*;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence dir_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {IDX_DIR, 2'b00};
  endsequence
  a_dir_ones: assert property (dir_read |=> s_axi_rvalid && s_axi_rdata == 32'h000000FF)
    else $error("direction read not all ones");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_norom_drive: assert property (op_mode == MAP_MODE_NOROM && !hw_standby |=> pin_oe == 8'hFF)
    else $error("address pins not driven");
  a_norom_addr: assert property (op_mode == MAP_MODE_NOROM |=> pin_out == $past(upper_address_bits))
    else $error("address pins wrong");
  a_hws_float: assert property (hw_standby |=> pin_oe == 8'h00)
    else $error("pins driven in standby");
  a_pull_off: assert property (hw_standby || op_mode == MAP_MODE_NOROM |=> pullup_en == 8'h00)
    else $error("pull-up on when forced off");
  a_pull_input: assert property ((pullup_en & pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
endmodule

bind map_port map_asserts map_asserts_inst (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .op_mode, .hw_standby,
  .upper_address_bits, .pin_out, .pin_oe, .pullup_en);

/* sim/map_board.sv */
// Board side of the port: external drivers, pull-ups and floating lines
module map_board (
  input wire logic        aclk,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pullup_en,
  input wire logic [7:0]  ext_val,
  input wire logic [7:0]  ext_en,
  output logic [7:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wig = 8'h55;
  // Undriven lines wander so a stale level never passes for a real one
  always @(posedge aclk) wig <= ~wig;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_en[i] ? 1'b1 : wig[i];
    end
  end
endmodule

/* sim/map_port_tb_top.sv */
// Self-checking bench for the mode-muxed address port
module map_port_tb_top;
  import map_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [7:0] uab = 8'h00, ev = 8'h00, ee = 8'hFF, po, poe, pue, pin, d;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hws = 0, sws = 0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr, resp;
  map_mode_t md = MAP_MODE_CHIP;
  int errors = 0, n_checks = 0, cyc = 0, m_dir, m_lat, m_pul;

  map_port map_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .op_mode(md), .hw_standby(hws), .sw_standby(sws), .upper_address_bits(uab), .pin_in(pin),
    .pin_out(po), .pin_oe(poe), .pullup_en(pue));
  map_board map_board_inst (.aclk(aclk), .pin_out(po), .pin_oe(poe), .pullup_en(pue), .ext_val(ev),
    .ext_en(ee), .pin_in(pin));

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] v, output logic [1:0] r);
    awa <= {ix, 2'b00};
    wd <= {24'h000000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    r = br;
    bry <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [15:0] ix, output logic [7:0] v, output logic [1:0] r);
    ara <= {ix, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rd[7:0];
    r = rr;
    rry <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rst(input map_mode_t m);
    aresetn <= 1'b0;
    md <= m;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Let the cleared pin synchroniser refill before the first port read
    repeat (3) @(posedge aclk);
    m_dir = 0;
    m_lat = 0;
    m_pul = 0;
  endtask
  function automatic logic [7:0] effd();
    return (md == MAP_MODE_NOROM) ? 8'hFF : m_dir[7:0];
  endfunction
  function automatic logic [7:0] exp_lat(input logic [7:0] p);
    return (effd() & m_lat[7:0]) | (~effd() & p);
  endfunction

  initial begin
    void'($urandom(32'h2384C914));
    for (int k = 0; k < 12; k++) begin
      rst(map_mode_t'(k[1:0]));
      rdr(IDX_PULLUP, d, resp); chk("pull_rst", 8'h00, d);
      rdr(IDX_LATCH, d, resp); chk("lat_rst", exp_lat(ev), d);
      chk("oe_rst", effd(), poe);
      ev <= $urandom;
      uab <= $urandom;
      d = $urandom; wr(IDX_DIR, d, resp); chk("wresp", RESP_OKAY, resp);
      if (md != MAP_MODE_NOROM) m_dir = d;
      d = $urandom; wr(IDX_LATCH, d, resp); m_lat = d;
      d = $urandom; wr(IDX_PULLUP, d, resp); m_pul = d;
      wr(16'hFFB0, 8'hA5, resp); chk("wr_unmapped", RESP_SLVERR, resp);
      rdr(16'hFFB2, d, resp); chk("rd_unmapped", RESP_SLVERR, resp);
      sws <= k[0];
      rdr(IDX_DIR, d, resp); chk("dir_rd", 8'hFF, d);
      rdr(IDX_LATCH, d, resp); chk("lat_rd", exp_lat(ev), d);
      rdr(IDX_PULLUP, d, resp); chk("pull_rd", m_pul, d);
      chk("oe", effd(), poe);
      chk("out", ((md == MAP_MODE_NOROM || md == MAP_MODE_ROM) ? uab : m_lat[7:0]) & effd(), po & effd());
      chk("pull", (md == MAP_MODE_NOROM) ? 8'h00 : m_pul[7:0] & ~m_dir[7:0], pue);
      hws <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("oe_hws", 8'h00, poe);
      chk("pull_hws", 8'h00, pue);
      hws <= 1'b0;
      m_dir = 0;
      m_lat = 0;
      m_pul = 0;
      repeat (3) @(posedge aclk);
      rdr(IDX_PULLUP, d, resp); chk("pull_hwclr", 8'h00, d);
      rdr(IDX_LATCH, d, resp); chk("lat_hwclr", exp_lat(ev), d);
    end
    rst(MAP_MODE_CHIP);
    wr(IDX_PULLUP, 8'hF0, resp);
    ee <= 8'h0F;
    repeat (4) @(posedge aclk);
    rdr(IDX_LATCH, d, resp); chk("pulled", {4'hF, ev[3:0]}, d);
    report_and_stop();
  end
endmodule
